/* File: rtl/dduc_map.svh */
// Register addresses, field positions and reset values for the converter pair
`ifndef DDUC_MAP_SVH
`define DDUC_MAP_SVH

`define DDUC_ADDR_W         8
`define DDUC_PAGE_W         8
`define DDUC_ADDR_C0_HIGH   8'hD3
`define DDUC_ADDR_C0_LOW    8'hD2
`define DDUC_ADDR_C0_CTRL   8'hD4
`define DDUC_ADDR_C1_HIGH   8'hD3
`define DDUC_ADDR_C1_LOW    8'hD2
`define DDUC_ADDR_C1_CTRL   8'hD4
`define DDUC_PAGE_C0        8'h00
`define DDUC_PAGE_C1        8'h01
`define DDUC_CTRL_EN_BIT    7
`define DDUC_CTRL_SRC_HI    4
`define DDUC_CTRL_SRC_LO    3
`define DDUC_CTRL_FMT_HI    2
`define DDUC_CTRL_FMT_LO    0
`define DDUC_CTRL_WMASK     8'h9F
`define DDUC_RESET_BYTE     8'h00
`define DDUC_RESET_CODE     12'h000

`endif

/* File: rtl/dduc_pkg.sv */
// Types shared by the converter update control files
package dduc_pkg;

   typedef enum logic [1:0] {
      DDUC_SRC_WRITE,
      DDUC_SRC_TMR3,
      DDUC_SRC_TMR4,
      DDUC_SRC_TMR2
   } dduc_src_t;

   typedef struct packed {
      logic       enable;
      logic [1:0] unused;
      dduc_src_t  source;
      logic [2:0] format;
   } dduc_ctrl_t;

   typedef struct packed {
      logic [7:0] high;
      logic [7:0] low;
   } dduc_data_t;

   typedef struct packed {
      logic tmr2;
      logic tmr3;
      logic tmr4;
   } dduc_tick_t;

endpackage

/* File: rtl/dduc_channel.sv */
// One converter channel: justification, update selection and input latch
`timescale 1ns/10ps
`include "dduc_map.svh"

module dduc_channel (
   input  wire logic               clk,
   input  wire logic               rst,
   input  wire dduc_pkg::dduc_ctrl_t ctrl,
   input  wire dduc_pkg::dduc_data_t data,
   input  wire logic               high_wr,
   input  wire dduc_pkg::dduc_tick_t tick,
   output logic [11:0]             code_reg,
   output logic                    enable_reg
);
   import dduc_pkg::*;

   logic [11:0] code_next;
   logic        load;
   logic        ovf;

   function automatic logic [11:0] justify(input logic [2:0] fmt,
                                           input dduc_data_t d);
      logic [11:0] w;
      w = {d.high[3:0], d.low};
      case (fmt)
         3'h1:    w = {d.high[4:0], d.low[7:1]};
         3'h2:    w = {d.high[5:0], d.low[7:2]};
         3'h3:    w = {d.high[6:0], d.low[7:3]};
         3'h0:    w = {d.high[3:0], d.low};
         default: w = {d.high, d.low[7:4]};
      endcase
      return w;
   endfunction

   always_comb begin
      case (ctrl.source)
         DDUC_SRC_WRITE: ovf = 1'b0;
         DDUC_SRC_TMR3:  ovf = tick.tmr3;
         DDUC_SRC_TMR4:  ovf = tick.tmr4;
         DDUC_SRC_TMR2:  ovf = tick.tmr2;
         default:        ovf = 1'b0;
      endcase
   end

   // Write mode latches only on a high-byte write; low writes wait
   assign load = (ctrl.source == DDUC_SRC_WRITE) ? high_wr
                                                 : ovf;
   // The high write lands in data this same edge, so the code is taken
   // one cycle later from the stored bytes; high_wr is delayed by caller
   assign code_next = justify(ctrl.format, data);

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         code_reg <= `DDUC_RESET_CODE;
      end else if (load) begin
         code_reg <= code_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         enable_reg <= 1'b0;
      end else begin
         enable_reg <= ctrl.enable;
      end
   end

endmodule

/* File: rtl/dduc_top.sv */
// Register file and update control for two 12-bit converter channels
`timescale 1ns/10ps
`include "dduc_map.svh"

// Functional notes
// - Control bit 7 low shuts the channel down; high makes the output active.
// - Control bits 6 and 5 read zero and ignore writes.
// - Update source 00 latches the word on a high-byte write.
// - Sources 01, 10, 11 latch on timer 3, timer 4, timer 2 overflow.
// - Format 000: high bits 3..0 on top, whole low byte below.
// - Format 001: high bits 4..0 on top, low bits 7..1 below.
// - Format 010: high bits 5..0 on top, low bits 7..2 below.
// - Format 011: high bits 6..0 on top, low bits 7..3 below.
// - Format 1xx: whole high byte on top, low bits 7..4 below.
// - Channel 0 low byte is an eight-bit read/write register.
// - Channel 1 high byte is read/write at D3 page 1, reset zero.
// - Channel 1 low byte is read/write at D2 page 1, reset zero.
// - Channel 1 uses the same justification encoding as channel 0.
// - Channel 0 control decodes at D4 on page 0; channel 1 data on page 1.
// - In write mode a low-byte write waits for the next high-byte write.
// - In timer modes both bytes wait until the selected overflow.
module dduc_top (
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic [`DDUC_PAGE_W-1:0]  sfr_page,
   input  wire logic [`DDUC_ADDR_W-1:0]  sfr_addr,
   input  wire logic                     sfr_wr,
   input  wire logic                     sfr_rd,
   input  wire logic [7:0]               sfr_wdata,
   input  wire logic                     tmr2_ovf,
   input  wire logic                     tmr3_ovf,
   input  wire logic                     tmr4_ovf,
   output logic [7:0]                    sfr_rdata_reg,
   output logic                          sfr_hit_reg,
   output logic [11:0]                   conv0_code,
   output logic [11:0]                   conv1_code,
   output logic                          conv0_enable,
   output logic                          conv1_enable
);
   import dduc_pkg::*;

   dduc_ctrl_t conv0_control_reg;
   dduc_ctrl_t conv1_control_reg;
   dduc_data_t conv0_data_reg;
   dduc_data_t conv1_data_reg;
   logic       conv0_high_wr_reg;
   logic       conv1_high_wr_reg;
   dduc_tick_t tick;
   logic       pg0;
   logic       pg1;
   logic [7:0] rdata_next;
   logic       hit_next;

   function automatic logic sel(input logic pg,
                                input logic [`DDUC_ADDR_W-1:0] a,
                                input logic [`DDUC_ADDR_W-1:0] want);
      return pg && (a == want);
   endfunction

   function automatic dduc_ctrl_t ctrl_wr(input logic [7:0] w);
      return dduc_ctrl_t'(w & `DDUC_CTRL_WMASK);
   endfunction

   assign pg0  = (sfr_page == `DDUC_PAGE_C0);
   assign pg1  = (sfr_page == `DDUC_PAGE_C1);
   // Overflows come from timers on this clock, one cycle wide each
   assign tick = '{tmr2: tmr2_ovf, tmr3: tmr3_ovf, tmr4: tmr4_ovf};

   // Channel 0 registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         conv0_control_reg <= dduc_ctrl_t'(`DDUC_RESET_BYTE);
         conv0_data_reg    <= dduc_data_t'({`DDUC_RESET_BYTE,
                                            `DDUC_RESET_BYTE});
      end else if (sfr_wr) begin
         if (sel(pg0, sfr_addr, `DDUC_ADDR_C0_CTRL)) begin
            conv0_control_reg <= ctrl_wr(sfr_wdata);
         end
         if (sel(pg0, sfr_addr, `DDUC_ADDR_C0_LOW)) begin
            conv0_data_reg.low <= sfr_wdata;
         end
         if (sel(pg0, sfr_addr, `DDUC_ADDR_C0_HIGH)) begin
            conv0_data_reg.high <= sfr_wdata;
         end
      end
   end

   // Channel 1 registers
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         conv1_control_reg <= dduc_ctrl_t'(`DDUC_RESET_BYTE);
         conv1_data_reg    <= dduc_data_t'({`DDUC_RESET_BYTE,
                                            `DDUC_RESET_BYTE});
      end else if (sfr_wr) begin
         if (sel(pg1, sfr_addr, `DDUC_ADDR_C1_CTRL)) begin
            conv1_control_reg <= ctrl_wr(sfr_wdata);
         end
         if (sel(pg1, sfr_addr, `DDUC_ADDR_C1_LOW)) begin
            conv1_data_reg.low <= sfr_wdata;
         end
         if (sel(pg1, sfr_addr, `DDUC_ADDR_C1_HIGH)) begin
            conv1_data_reg.high <= sfr_wdata;
         end
      end
   end

   // High-byte write strobes, delayed one cycle so the channel sees the
   // stored byte; a timer load in between would use the same bytes anyway
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         conv0_high_wr_reg <= 1'b0;
         conv1_high_wr_reg <= 1'b0;
      end else begin
         conv0_high_wr_reg <= sfr_wr &&
            sel(pg0, sfr_addr, `DDUC_ADDR_C0_HIGH);
         conv1_high_wr_reg <= sfr_wr &&
            sel(pg1, sfr_addr, `DDUC_ADDR_C1_HIGH);
      end
   end

   always_comb begin
      rdata_next = `DDUC_RESET_BYTE;
      hit_next   = 1'b1;
      if (sel(pg0, sfr_addr, `DDUC_ADDR_C0_CTRL)) begin
         rdata_next = conv0_control_reg & `DDUC_CTRL_WMASK;
      end else if (sel(pg0, sfr_addr, `DDUC_ADDR_C0_LOW)) begin
         rdata_next = conv0_data_reg.low;
      end else if (sel(pg0, sfr_addr, `DDUC_ADDR_C0_HIGH)) begin
         rdata_next = conv0_data_reg.high;
      end else if (sel(pg1, sfr_addr, `DDUC_ADDR_C1_CTRL)) begin
         rdata_next = conv1_control_reg & `DDUC_CTRL_WMASK;
      end else if (sel(pg1, sfr_addr, `DDUC_ADDR_C1_LOW)) begin
         rdata_next = conv1_data_reg.low;
      end else if (sel(pg1, sfr_addr, `DDUC_ADDR_C1_HIGH)) begin
         rdata_next = conv1_data_reg.high;
      end else begin
         hit_next = 1'b0;
      end
   end

   // Read data is registered; unmapped addresses read zero with no hit
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sfr_rdata_reg <= `DDUC_RESET_BYTE;
         sfr_hit_reg   <= 1'b0;
      end else if (sfr_rd) begin
         sfr_rdata_reg <= rdata_next;
         sfr_hit_reg   <= hit_next;
      end else begin
         sfr_hit_reg   <= 1'b0;
      end
   end

   dduc_channel u_conv0 (
      .clk        (clk),
      .rst        (rst),
      .ctrl       (conv0_control_reg),
      .data       (conv0_data_reg),
      .high_wr    (conv0_high_wr_reg),
      .tick       (tick),
      .code_reg   (conv0_code),
      .enable_reg (conv0_enable)
   );

   dduc_channel u_conv1 (
      .clk        (clk),
      .rst        (rst),
      .ctrl       (conv1_control_reg),
      .data       (conv1_data_reg),
      .high_wr    (conv1_high_wr_reg),
      .tick       (tick),
      .code_reg   (conv1_code),
      .enable_reg (conv1_enable)
   );

endmodule

/* File: test/dduc_checker.sv */
// Port-level timing checks for the converter pair
`timescale 1ns/10ps
module dduc_checker (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic [7:0]  sfr_page,
   input wire logic [7:0]  sfr_addr,
   input wire logic        sfr_wr,
   input wire logic        sfr_rd,
   input wire logic [7:0]  sfr_wdata,
   input wire logic        tmr2_ovf,
   input wire logic        tmr3_ovf,
   input wire logic        tmr4_ovf,
   input wire logic [7:0]  sfr_rdata_reg,
   input wire logic        sfr_hit_reg,
   input wire logic [11:0] conv0_code,
   input wire logic [11:0] conv1_code,
   input wire logic        conv0_enable,
   input wire logic        conv1_enable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic hi0, hi1, ct0, ct1, ovf;
   assign hi0 = sfr_wr && sfr_addr == 8'hD3 && sfr_page == 8'h00;
   assign hi1 = sfr_wr && sfr_addr == 8'hD3 && sfr_page == 8'h01;
   assign ct0 = sfr_wr && sfr_addr == 8'hD4 && sfr_page == 8'h00;
   assign ct1 = sfr_wr && sfr_addr == 8'hD4 && sfr_page == 8'h01;
   assign ovf = tmr2_ovf || tmr3_ovf || tmr4_ovf;
   sequence s_map_rd;
      sfr_rd && sfr_page < 8'h02 && sfr_addr inside {[8'hD2:8'hD4]};
   endsequence
   // High write loads one edge after it lands; an overflow loads at once
   sequence s_load0;
      $past(hi0, 2) || $past(ovf);
   endsequence
   sequence s_load1;
      $past(hi1, 2) || $past(ovf);
   endsequence
   a_hit_needs_read: assert property (!sfr_rd |=> !sfr_hit_reg)
      else $error("hit flag without a read");
   a_unmapped_read: assert property (sfr_rd && sfr_page > 8'h01
      |=> !sfr_hit_reg && sfr_rdata_reg == 8'h00) else $error("unmapped read");
   a_mapped_hit: assert property (s_map_rd |=> sfr_hit_reg)
      else $error("mapped read without hit");
   a_ctrl_unused_zero: assert property (sfr_rd && sfr_addr == 8'hD4
      |=> sfr_rdata_reg[6:5] == 2'b00) else $error("unused bits nonzero");
   a_rdata_holds: assert property (!sfr_rd |=> $stable(sfr_rdata_reg))
      else $error("read data moved");
   a_code0_cause: assert property ($changed(conv0_code) |-> s_load0)
      else $error("code0 changed without load");
   a_code1_cause: assert property ($changed(conv1_code) |-> s_load1)
      else $error("code1 changed without load");
   a_enable0_cause: assert property ($changed(conv0_enable)
      |-> $past(ct0) || $past(ct0, 2)) else $error("enable0 moved");
   a_enable1_cause: assert property ($changed(conv1_enable)
      |-> $past(ct1) || $past(ct1, 2)) else $error("enable1 moved");
endmodule

bind dduc_top dduc_checker u_chk (.clk(clk), .rst(rst), .sfr_page(sfr_page),
   .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
   .sfr_wdata(sfr_wdata), .tmr2_ovf(tmr2_ovf), .tmr3_ovf(tmr3_ovf),
   .tmr4_ovf(tmr4_ovf), .sfr_rdata_reg(sfr_rdata_reg),
   .sfr_hit_reg(sfr_hit_reg), .conv0_code(conv0_code),
   .conv1_code(conv1_code), .conv0_enable(conv0_enable),
   .conv1_enable(conv1_enable));

/* File: test/dual_dac_update_control_test.sv */
// Self-checking bench for the converter pair registers and update logic
`timescale 1ns/10ps
`include "dduc_map.svh"
module dual_dac_update_control_test;
   logic [7:0]  sfr_page = '0, sfr_addr = '0, sfr_wdata = '0, sfr_rdata_reg;
   logic        clk = 1'b0, rst = 1'b1, sfr_wr = 1'b0, sfr_rd = 1'b0;
   logic        sfr_hit_reg;
   logic        tmr2_ovf = 1'b0, tmr3_ovf = 1'b0, tmr4_ovf = 1'b0;
   logic        conv0_enable, conv1_enable;
   logic [11:0] conv0_code, conv1_code;
   int          error_cnt = 0, cmp_count = 0, cyc = 0;
   dduc_top dut (.clk(clk), .rst(rst), .sfr_page(sfr_page),
      .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
      .sfr_wdata(sfr_wdata), .tmr2_ovf(tmr2_ovf), .tmr3_ovf(tmr3_ovf),
      .tmr4_ovf(tmr4_ovf), .sfr_rdata_reg(sfr_rdata_reg),
      .sfr_hit_reg(sfr_hit_reg), .conv0_code(conv0_code),
      .conv1_code(conv1_code), .conv0_enable(conv0_enable),
      .conv1_enable(conv1_enable));
   always #5 clk = ~clk;
   task stop_test;
      $display("errors %0d compares %0d", error_cnt, cmp_count);
      if (error_cnt == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Whole run needs well under a thousand cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         stop_test();
      end
   end
   task chk(input string n, input logic [11:0] e, input logic [11:0] g);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      {sfr_page, sfr_addr, sfr_wdata, sfr_wr} = {p, a, d, 1'b1};
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask
   task rd(input logic [7:0] p, input logic [7:0] a, output logic [8:0] r);
      @(negedge clk);
      {sfr_page, sfr_addr, sfr_rd} = {p, a, 1'b1};
      @(negedge clk);
      sfr_rd = 1'b0;
      r = {sfr_hit_reg, sfr_rdata_reg};
   endtask
   task tick(input logic [2:0] m);
      @(negedge clk);
      {tmr2_ovf, tmr3_ovf, tmr4_ovf} = m;
      @(negedge clk);
      {tmr2_ovf, tmr3_ovf, tmr4_ovf} = 3'b000;
      repeat (2) @(negedge clk);
   endtask
   function logic [11:0] fc(input logic [2:0] f, input logic [7:0] h, l);
      case (f)
         3'h0: fc = {h[3:0], l};
         3'h1: fc = {h[4:0], l[7:1]};
         3'h2: fc = {h[5:0], l[7:2]};
         3'h3: fc = {h[6:0], l[7:3]};
         default: fc = {h, l[7:4]};
      endcase
   endfunction
   function logic [11:0] code(input int c);
      code = c ? conv1_code : conv0_code;
   endfunction
   initial begin
      logic [8:0] r;
      logic [7:0] p, hb, lb;
      logic [2:0] f, m;
      logic [11:0] e;
      repeat (5) @(posedge clk);
      @(negedge clk) rst = 0;
      for (int a = 8'hD2; a <= 8'hD4; a++)
         for (int c = 0; c < 2; c++) begin
            rd(8'(c), 8'(a), r);
            chk("reset read", 12'h100, {3'h0, r});
         end
      wr(8'h02, `DDUC_ADDR_C0_CTRL, 8'hFF);
      rd(8'h02, `DDUC_ADDR_C0_CTRL, r);
      chk("unmapped read", 12'h000, {3'h0, r});
      rd(`DDUC_PAGE_C0, `DDUC_ADDR_C0_CTRL, r);
      chk("ignored write", 12'h100, {3'h0, r});
      for (int c = 0; c < 2; c++) begin
         p = c ? `DDUC_PAGE_C1 : `DDUC_PAGE_C0;
         e = 12'h000;
         wr(p, `DDUC_ADDR_C0_CTRL, 8'hFF);
         rd(p, `DDUC_ADDR_C0_CTRL, r);
         chk("control", 12'h19F, {3'h0, r});
         chk("enable", 12'h001, 12'(c ? conv1_enable : conv0_enable));
         chk("peer en", 12'h000, 12'(c ? conv0_enable : conv1_enable));
         for (int i = 0; i < 6; i++) begin
            f = (i == 5) ? 3'h7 : 3'(i);
            hb = 8'h96 + 8'(i * 8'h13);
            lb = 8'hC5 ^ 8'(i * 8'h21);
            wr(p, `DDUC_ADDR_C0_CTRL, 8'h80 | 8'(f));
            wr(p, `DDUC_ADDR_C0_LOW, lb);
            repeat (3) @(negedge clk);
            chk("held low", e, code(c));
            wr(p, `DDUC_ADDR_C0_HIGH, hb);
            repeat (2) @(negedge clk);
            e = fc(f, hb, lb);
            chk("format", e, code(c));
         end
         rd(p, `DDUC_ADDR_C0_LOW, r);
         chk("low reg", {4'h1, lb}, {3'h0, r});
         rd(p, `DDUC_ADDR_C0_HIGH, r);
         chk("high reg", {4'h1, hb}, {3'h0, r});
         for (int s = 1; s < 4; s++) begin
            m = (s == 1) ? 3'b010 : (s == 2) ? 3'b001 : 3'b100;
            hb = 8'h0A + 8'(s);
            lb = 8'h50 + 8'(s * 8'h11);
            wr(p, `DDUC_ADDR_C0_CTRL, 8'h80 | 8'(s << 3));
            wr(p, `DDUC_ADDR_C0_LOW, lb);
            wr(p, `DDUC_ADDR_C0_HIGH, hb);
            repeat (3) @(negedge clk);
            chk("held writes", e, code(c));
            tick(~m);
            chk("other timers", e, code(c));
            tick(m);
            e = {hb[3:0], lb};
            chk("timer load", e, code(c));
         end
         wr(p, `DDUC_ADDR_C0_CTRL, 8'h00);
         @(negedge clk);
         chk("shutdown", 12'h000, 12'(c ? conv1_enable : conv0_enable));
      end
      stop_test();
   end
endmodule
